// ---- rtl/rx_cfg_pkg.sv ----
// package: register map, field layout, reset values and counts of the rx configuration bank
package rx_cfg_pkg;
  // register byte addresses
  localparam logic [7:0] preamble_cfg_addr = 8'h00;
  localparam logic [7:0] mixer_cfg_addr = 8'h04;
  localparam logic [7:0] image_cfg_addr = 8'h08;
  localparam logic [7:0] status_addr = 8'h0c;
  localparam logic [7:0] coeff_i_high_addr = 8'h10;
  localparam logic [7:0] coeff_i_low_addr = 8'h14;
  localparam logic [7:0] coeff_q_high_addr = 8'h18;
  localparam logic [7:0] coeff_q_low_addr = 8'h1c;
  // preamble detection register fields
  localparam int detect_on_bit = 5;
  localparam int startup_len_bit = 4;
  localparam int thr_msb = 3;
  localparam logic [7:0] preamble_cfg_wmask = 8'h3f;
  localparam logic [7:0] preamble_cfg_rst = 8'h2a;
  // mixer word reset
  localparam logic [7:0] mixer_word_rst = 8'h40;
  // image compensation register fields
  localparam int image_on_bit = 7;
  localparam int coeff_update_bit = 6;
  localparam int settle_len_msb = 5;
  localparam int settle_len_lsb = 4;
  localparam logic [7:0] image_cfg_wmask = 8'hf0;
  localparam logic [7:0] image_cfg_rst = 8'hc0;
  // start-up symbol counts
  localparam logic [5:0] startup_short = 6'h10;
  localparam logic [5:0] startup_long = 6'h2b;
  // settling block lengths in samples
  localparam logic [8:0] settle_len_0 = 9'h008;
  localparam logic [8:0] settle_len_1 = 9'h020;
  localparam logic [8:0] settle_len_2 = 9'h080;
  localparam logic [8:0] settle_len_3 = 9'h100;
  // mixer phase accumulator width
  localparam int phase_width = 15;
endpackage : rx_cfg_pkg

// ---- rtl/rx_preamble_if_image_config.sv ----
// rx preamble qualifier, mixer word and image compensation configuration bank with apb slave
//
// Design decisions made here: the register offsets and register access over APB.
module rx_preamble_if_image_config (
  input wire logic pclk, // apb clock, 25 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high writes
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready, one wait state
  output logic pslverr, // apb error on unmapped address
  input wire logic rx_start, // pulse: a new reception begins
  input wire logic symbol_strobe, // pulse: one symbol received
  input wire logic [3:0] qualifier_error_value, // preamble qualifier error of this symbol
  output logic preamble_valid_flag, // level: preamble detected this reception
  output logic [14:0] mixer_phase, // digital mixer phase accumulator
  output logic image_comp_active, // level: compensation applied to samples
  input wire logic settle_start, // pulse: begin coarse estimate block
  input wire logic settle_sample, // pulse: one sample during settling
  output logic settle_done, // pulse: coarse estimate block complete
  input wire logic coeff_est_valid, // pulse: new coefficient estimate
  input wire logic [31:0] coeff_est // estimate: i high, i low, q high, q low bytes
);
  // register state
  logic [5:0] preamble_cfg_r, preamble_cfg_nxt; // only low six bits are storage
  logic [7:0] mixer_word_r, mixer_word_nxt; // signed mixer frequency word
  logic [7:0] image_cfg_r, image_cfg_nxt; // upper nibble holds the fields
  logic [31:0] coeff_r, coeff_nxt; // four coefficient bytes
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r, prdata_nxt;
  // datapath state
  logic [5:0] sym_cnt_r, sym_cnt_nxt; // saturates at the long start-up count
  logic valid_r, valid_nxt;
  logic [14:0] phase_r, phase_nxt;
  logic image_r;
  logic settle_busy_r, settle_busy_nxt;
  logic [8:0] settle_cnt_r, settle_cnt_nxt;
  logic settle_done_r, settle_done_nxt;

  // bus decode
  wire access = psel && penable && !pready_r; // answer one cycle after access starts
  wire commit = psel && penable && pready_r; // write takes effect here
  wire sel_pre = paddr == rx_cfg_pkg::preamble_cfg_addr;
  wire sel_mix = paddr == rx_cfg_pkg::mixer_cfg_addr;
  wire sel_img = paddr == rx_cfg_pkg::image_cfg_addr;
  wire sel_sts = paddr == rx_cfg_pkg::status_addr;
  wire sel_cih = paddr == rx_cfg_pkg::coeff_i_high_addr;
  wire sel_cil = paddr == rx_cfg_pkg::coeff_i_low_addr;
  wire sel_cqh = paddr == rx_cfg_pkg::coeff_q_high_addr;
  wire sel_cql = paddr == rx_cfg_pkg::coeff_q_low_addr;
  wire mapped = sel_pre | sel_mix | sel_img | sel_sts | sel_cih | sel_cil | sel_cqh | sel_cql;
  wire wr = commit && pwrite && mapped;

  // field views
  wire detect_on = preamble_cfg_r[rx_cfg_pkg::detect_on_bit];
  wire long_start = preamble_cfg_r[rx_cfg_pkg::startup_len_bit];
  wire [3:0] threshold = preamble_cfg_r[rx_cfg_pkg::thr_msb:0];
  wire image_on = image_cfg_r[rx_cfg_pkg::image_on_bit];
  wire update_on = image_cfg_r[rx_cfg_pkg::coeff_update_bit];
  wire [1:0] settle_sel = image_cfg_r[rx_cfg_pkg::settle_len_msb:rx_cfg_pkg::settle_len_lsb];

  // register writes; unused preamble bits have no storage at all
  wire [7:0] pre_w = pwdata[7:0] & rx_cfg_pkg::preamble_cfg_wmask;
  assign preamble_cfg_nxt = (wr && sel_pre) ? pre_w[5:0] : preamble_cfg_r;
  assign mixer_word_nxt = (wr && sel_mix) ? pwdata[7:0] : mixer_word_r;
  assign image_cfg_nxt = (wr && sel_img) ? (pwdata[7:0] & rx_cfg_pkg::image_cfg_wmask)
                                         : image_cfg_r;
  // estimator writes coefficients only while updating is allowed; software cannot write them
  assign coeff_nxt = (coeff_est_valid && update_on) ? coeff_est : coeff_r;

  // read mux, upper bits read zero
  assign prdata_nxt = sel_pre ? {26'h0, preamble_cfg_r} :
                      sel_mix ? {24'h000000, mixer_word_r} :
                      sel_img ? {24'h000000, image_cfg_r} :
                      sel_sts ? {22'h0, settle_busy_r, image_r, sym_cnt_r, 1'b0, valid_r} :
                      sel_cih ? {24'h000000, coeff_r[31:24]} :
                      sel_cil ? {24'h000000, coeff_r[23:16]} :
                      sel_cqh ? {24'h000000, coeff_r[15:8]} :
                      sel_cql ? {24'h000000, coeff_r[7:0]} : 32'h00000000;

  // symbol counting since the start of this reception
  wire [5:0] startup_len = long_start ? rx_cfg_pkg::startup_long
                                      : rx_cfg_pkg::startup_short;
  wire sym_sat = sym_cnt_r == rx_cfg_pkg::startup_long;
  assign sym_cnt_nxt = rx_start ? 6'h00 :
                       (symbol_strobe && !sym_sat) ? sym_cnt_r + 6'h01 : sym_cnt_r;
  wire startup_met = sym_cnt_r >= startup_len;
  wire quality_ok = qualifier_error_value < threshold; // strict compare
  // once detected the flag holds for the reception; disabling drops it at once
  assign valid_nxt = (!detect_on || rx_start) ? 1'b0 :
                     (valid_r || (symbol_strobe && startup_met && quality_ok));

  // mixer nco: step per clock is the signed word, so f = fclk * word / 2^15
  wire [14:0] step = {{7{mixer_word_r[7]}}, mixer_word_r}; // sign extend
  assign phase_nxt = phase_r + step; // wraps modulo 2^15

  // settling block length select
  wire [8:0] settle_len = (settle_sel == 2'b00) ? rx_cfg_pkg::settle_len_0 :
                          (settle_sel == 2'b01) ? rx_cfg_pkg::settle_len_1 :
                          (settle_sel == 2'b10) ? rx_cfg_pkg::settle_len_2 :
                                                  rx_cfg_pkg::settle_len_3;
  wire last_sample = settle_busy_r && settle_sample && (settle_cnt_r == settle_len - 9'h001);
  assign settle_busy_nxt = settle_start ? 1'b1 : (last_sample ? 1'b0 : settle_busy_r);
  assign settle_cnt_nxt = settle_start ? 9'h000 :
                          (settle_busy_r && settle_sample) ? settle_cnt_r + 9'h001 :
                          settle_cnt_r;
  assign settle_done_nxt = last_sample && !settle_start; // restart wins over completion

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= access;
      pslverr_r <= access && !mapped;
      prdata_r <= (access && !pwrite) ? prdata_nxt : 32'h00000000;
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      preamble_cfg_r <= rx_cfg_pkg::preamble_cfg_rst[5:0];
      mixer_word_r <= rx_cfg_pkg::mixer_word_rst;
      image_cfg_r <= rx_cfg_pkg::image_cfg_rst;
      coeff_r <= 32'h00000000;
    end
    else
    begin
      preamble_cfg_r <= preamble_cfg_nxt;
      mixer_word_r <= mixer_word_nxt;
      image_cfg_r <= image_cfg_nxt;
      coeff_r <= coeff_nxt;
    end
  end

  // datapath state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sym_cnt_r <= 6'h00;
      valid_r <= 1'b0;
      phase_r <= 15'h0000;
      image_r <= 1'b0;
      settle_busy_r <= 1'b0;
      settle_cnt_r <= 9'h000;
      settle_done_r <= 1'b0;
    end
    else
    begin
      sym_cnt_r <= sym_cnt_nxt;
      valid_r <= valid_nxt;
      phase_r <= phase_nxt;
      image_r <= image_on; // bypass when zero
      settle_busy_r <= settle_busy_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      settle_done_r <= settle_done_nxt;
    end
  end

  // outputs, all from flip-flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign preamble_valid_flag = valid_r;
  assign mixer_phase = phase_r;
  assign image_comp_active = image_r;
  assign settle_done = settle_done_r;

  // checks
  a_detect_off_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !detect_on |=> !valid_r) else $error("flag set while detection off");
  a_startup_withheld: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(valid_r) |-> $past(sym_cnt_r) >= ($past(long_start) ? rx_cfg_pkg::startup_long
                                                              : rx_cfg_pkg::startup_short))
    else $error("flag before start-up count");
  a_quality_strict: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(valid_r) |-> $past(qualifier_error_value) < $past(threshold))
    else $error("flag without error below threshold");
  // the presetn guard skips the release edge, at which the flops still sit in reset
  a_mixer_step: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> phase_r == 15'($past(phase_r)
      + {{7{$past(mixer_word_r[7])}}, $past(mixer_word_r)}))
    else $error("mixer step not signed word");
  a_negative_word: assert property (@(posedge pclk) disable iff (!presetn)
    (mixer_word_r == 8'hff) |=> phase_r == 15'($past(phase_r) - 15'h0001))
    else $error("negative word not subtracting");
  a_image_follow: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> image_r == $past(image_on)) else $error("compensation not following enable");
  a_coeff_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    !update_on |=> $stable(coeff_r)) else $error("coefficients changed while frozen");
  a_settle_short: assert property (@(posedge pclk) disable iff (!presetn)
    (settle_start && settle_sel == 2'b00 && !(wr && sel_img))
    ##1 (settle_sample && !settle_start)[*8]
    |=> settle_done_r) else $error("short settle block not done after 8");
  a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pready_r && !pwrite && sel_pre) |-> prdata_r[7:6] == 2'b00)
    else $error("unused preamble bits not zero");
  c_detect: cover property (@(posedge pclk) disable iff (!presetn) $rose(valid_r));
  c_coeff_update: cover property (@(posedge pclk) disable iff (!presetn)
    coeff_est_valid && update_on);
  c_settle_done: cover property (@(posedge pclk) disable iff (!presetn) settle_done_r);
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr_r);
endmodule // rx_preamble_if_image_config

// ---- testbench/apb_host.sv ----
// host model: apb master that configures the receive bank
module apb_host (
  input wire logic pclk, // bus clock
  input wire logic pready, // slave ready
  output logic psel = 1'b0, // select
  output logic penable = 1'b0, // access phase
  output logic pwrite = 1'b0, // direction, high writes
  output logic [7:0] paddr = 8'h00, // byte address
  output logic [31:0] pwdata = 32'h0 // write data
);
  timeunit 1ns;
  timeprecision 1ns;
  // one transfer; the host drives address and data as given, with no check
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // hold everything until ready is seen at an edge
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show garbage, not the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // apb_host

// ---- testbench/rx_preamble_if_image_config_tb.sv ----
// self-checking bench for the receive configuration bank
module rx_preamble_if_image_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0; // 25 MHz clock
  logic presetn = 1'b0; // reset, active low
  logic rx_start = 0, symbol_strobe = 0, settle_start = 0, settle_sample = 0;
  logic coeff_est_valid = 0; // estimate strobe
  logic [3:0] qualifier_error_value = 4'h0; // error per symbol
  logic [31:0] coeff_est = 32'h0, prdata, pwdata, rng = 32'd32237; // estimate, bus, seed
  logic [31:0] est0; // first estimate, kept to prove the freeze
  logic [7:0] paddr; // bus address
  logic [7:0] words[4]; // mixer words under test
  logic psel, penable, pwrite, pready, pslverr, preamble_valid_flag, image_comp_active;
  logic settle_done; // settling block end
  logic [14:0] mixer_phase, phase0; // phase and a snapshot
  logic [32:0] expq[$]; // expected {pslverr, prdata} per transfer
  int n_fail = 0, checks_done = 0, lens[4] = '{8, 32, 128, 256};
  always #20 pclk = ~pclk;
  apb_host host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  rx_preamble_if_image_config uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_start(rx_start), .symbol_strobe(symbol_strobe),
    .qualifier_error_value(qualifier_error_value), .preamble_valid_flag(preamble_valid_flag),
    .mixer_phase(mixer_phase), .image_comp_active(image_comp_active),
    .settle_start(settle_start), .settle_sample(settle_sample), .settle_done(settle_done),
    .coeff_est_valid(coeff_est_valid), .coeff_est(coeff_est));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watcher: each bus answer is paired with the oldest note
  always @(posedge pclk)
    if (pready === 1'b1)
      check({pslverr, prdata}, expq.size() ? expq.pop_front() : 33'h1ffffffff);
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    expq.push_back(33'h0);
    host.xfer(1'b1, a, {24'h0, d});
  endtask
  // one reception: start pulse, n symbols at a fixed error, flag checked after
  task automatic pre(input int n, input logic [3:0] err, input logic exp);
    @(posedge pclk);
    rx_start <= 1'b1;
    @(posedge pclk);
    rx_start <= 1'b0;
    symbol_strobe <= 1'b1;
    qualifier_error_value <= err;
    repeat (n) @(posedge pclk);
    symbol_strobe <= 1'b0;
    #1 check(preamble_valid_flag, exp);
  endtask
  // settling block of n samples; done must not come early
  task automatic settle(input int n);
    @(posedge pclk);
    settle_start <= 1'b1;
    @(posedge pclk);
    settle_start <= 1'b0;
    settle_sample <= 1'b1;
    repeat (n - 1) @(posedge pclk);
    #1 check(settle_done, 0);
    @(posedge pclk);
    settle_sample <= 1'b0;
    #1 check(settle_done, 1);
  endtask
  // xorshift step for the random stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // one random coefficient estimate
  task automatic est();
    rng = xs(rng);
    @(posedge pclk);
    coeff_est_valid <= 1'b1;
    coeff_est <= rng;
    @(posedge pclk);
    coeff_est_valid <= 1'b0;
  endtask
  initial
  begin
    #400000;
    n_fail++;
    stop_test();
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(rx_cfg_pkg::preamble_cfg_addr, 33'h2a);
    rd(rx_cfg_pkg::mixer_cfg_addr, 33'h40);
    wr(rx_cfg_pkg::image_cfg_addr, 8'hcf);
    rd(rx_cfg_pkg::image_cfg_addr, 33'hc0);
    wr(8'h00, 8'hff);
    rd(8'h00, 33'h3f);
    rd(8'h20, {1'b1, 32'h0}); // unmapped place answers with an error
    wr(8'h00, 8'h2a);
    pre(16, 4'h3, 1'b0);
    pre(17, 4'h3, 1'b1);
    pre(17, 4'ha, 1'b0);
    pre(17, 4'h9, 1'b1);
    wr(8'h00, 8'h3a);
    pre(43, 4'h3, 1'b0);
    pre(44, 4'h3, 1'b1);
    wr(8'h00, 8'h1a);
    @(posedge pclk);
    #1 check(preamble_valid_flag, 0);
    pre(17, 4'h0, 1'b0);
    est();
    est0 = coeff_est;
    words = '{8'h80, 8'h7f, 8'hff, coeff_est[7:0]};
    foreach (words[i])
    begin
      wr(8'h04, words[i]);
      rd(8'h04, {25'h0, words[i]});
      #1 phase0 = mixer_phase;
      @(posedge pclk);
      #1 check(mixer_phase, 15'(phase0 + {{7{words[i][7]}}, words[i]}));
    end
    wr(8'h08, 8'h00);
    @(posedge pclk);
    #1 check(image_comp_active, 0);
    est();
    rd(8'h10, {25'h0, est0[31:24]});
    wr(8'h08, 8'h40);
    est();
    for (int i = 0; i < 4; i++)
      rd(8'(8'h10 + 4 * i), {25'h0, coeff_est[31 - 8 * i -: 8]});
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h08, 8'(8'hc0 | (c << 4)));
      settle(lens[c]);
      check(image_comp_active, 1);
    end
    // reset in mid-run: registers and outputs return to their reset values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1 check({image_comp_active, preamble_valid_flag, mixer_phase}, 33'h0);
    @(posedge pclk);
    #1 check({image_comp_active, mixer_phase}, {1'b1, 15'h0040});
    rd(rx_cfg_pkg::preamble_cfg_addr, 33'h2a);
    rd(rx_cfg_pkg::image_cfg_addr, 33'hc0);
    rd(rx_cfg_pkg::coeff_i_high_addr, 33'h0);
    rd(rx_cfg_pkg::status_addr, 33'h100);
    @(posedge pclk);
    stop_test();
  end
endmodule // rx_preamble_if_image_config_tb
